// ### rtl/rx_mode_config_bank.sv
// Receiver mode table for modes 10 to 14 behind a classic Wishbone slave.
//
// How it works
// R01: Gain bytes hold two 3-bit codes in bits 6:4 and 2:0, bits 7 and 3 read zero.
// R02: Enable bytes hold main splitter at 6, pair splitters at 5 and 4, channels at 3:0.
// R03: Mode 10 gain codes all come out of reset at four.
// R04: Mode 10 channel enables all come out of reset set.
// R05: Mode 11, 12 and 13 gain codes all come out of reset at zero.
// R06: Mode 11 resets to main splitter, pair one splitter and channel one only.
// R07: Mode 12 resets to main splitter, pair one splitter and channel two only.
// R08: Mode 13 resets to main splitter, pair two splitter and channel three only.
// R09: Mode 14 resets to main splitter, pair two splitter and channel four only.
// R10: Writable fields read back what was written and reserved bits stay zero.
// R11: The selected mode's splitters and channels drive the receiver controls, with gains from modes 10 to 13 and zero gains in mode 14.
`timescale 1ns/1ps
`include "rx_mode_defines.svh"
module rx_mode_config_bank
  import rx_mode_pkg::*;
(
  input  wire logic                   mclk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [`ADR_WIDTH-1:0]  wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic                        wb_ack_o,
  output logic [31:0]                 wb_dat_o,
  input  wire mode_index_type         mode_sel_i,
  output logic                        main_splitter_o,
  output logic                        pair_one_splitter_o,
  output logic                        pair_two_splitter_o,
  output logic [3:0]                  channel_on_o,
  output gain_code_type               gain_ch1_o,
  output gain_code_type               gain_ch2_o,
  output gain_code_type               gain_ch3_o,
  output gain_code_type               gain_ch4_o,
  output logic                        mode_known_o
);

  // Decodes a word index into {hit, slot}; slot 0 is the mode 10 enables.
  function automatic logic [4:0] decode_slot(input logic [`IDX_WIDTH-1:0] idx);
    logic [4:0] res;
    res = 5'h00;
    unique case (idx)
      `MODE10_ENABLES_IDX:      res = 5'h10;
      `RX_MODE10_GAIN_CH12_IDX: res = 5'h11;
      `RX_MODE10_GAIN_CH34_IDX: res = 5'h12;
      `RX_MODE11_ENABLES_IDX:   res = 5'h13;
      `RX_MODE11_GAIN_CH12_IDX: res = 5'h14;
      `RX_MODE11_GAIN_CH34_IDX: res = 5'h15;
      `RX_MODE12_ENABLES_IDX:   res = 5'h16;
      `RX_MODE12_GAIN_CH12_IDX: res = 5'h17;
      `RX_MODE12_GAIN_CH34_IDX: res = 5'h18;
      `RX_MODE13_ENABLES_IDX:   res = 5'h19;
      `RX_MODE13_GAIN_CH12_IDX: res = 5'h1A;
      `RX_MODE13_GAIN_CH34_IDX: res = 5'h1B;
      `RX_MODE14_ENABLES_IDX:   res = 5'h1C;
      default:                  res = 5'h00;
    endcase
    return res;
  endfunction : decode_slot

  // Every third slot, starting at slot 0, is an enable byte.
  function automatic logic slot_is_enable(input int k);
    return (k % 3) == 0;
  endfunction : slot_is_enable

  function automatic cfg_byte_type slot_mask(input int k);
    return slot_is_enable(k) ? `ENABLE_MASK : `GAIN_MASK; // R01 R02
  endfunction : slot_mask

  function automatic cfg_byte_type slot_reset(input int k);
    cfg_byte_type v;
    v = `RST_ZERO_GAIN;
    unique case (k)
      0:       v = `RST_MODE10_ENABLES; // R04
      1, 2:    v = `RST_MODE10_GAIN; // R03
      3:       v = `RST_MODE11_ENABLES; // R06
      6:       v = `RST_MODE12_ENABLES; // R07
      9:       v = `RST_MODE13_ENABLES; // R08
      12:      v = `RST_MODE14_ENABLES; // R09
      default: v = `RST_ZERO_GAIN; // R05
    endcase
    return v;
  endfunction : slot_reset

  logic [`IDX_WIDTH-1:0] req_idx;
  logic [4:0]            req_dec;
  logic                  req_hit;
  slot_type              req_slot;
  logic                  bus_req;
  logic                  wr_fire;
  logic                  rd_fire;
  cfg_byte_type          slot_value [0:`SLOT_COUNT-1];
  logic [103:0]          table_flat;

  assign req_idx  = wb_adr_i[`ADR_WIDTH-1:2];
  assign req_dec  = decode_slot(req_idx);
  assign req_hit  = req_dec[4];
  assign req_slot = req_dec[3:0];
  // A request is taken only while no answer is standing.
  assign bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Only byte lane 0 carries a register; other lanes are ignored.
  assign wr_fire  = bus_req && wb_we_i && wb_sel_i[0] && req_hit;
  assign rd_fire  = bus_req && !wb_we_i;

  // Answer one cycle after the request, then drop for a cycle.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Unmapped reads return zero; the upper bytes always read zero.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_fire && req_hit) begin
      wb_dat_o <= {24'h00_0000, slot_value[req_slot]};
    end else begin
      wb_dat_o <= 32'h0000_0000;
    end
  end

  genvar k;
  generate
    for (k = 0; k < `SLOT_COUNT; k++) begin : g_slot
      rx_cfg_byte #(
        .RESET_VALUE (slot_reset(k)),
        .WRITE_MASK  (slot_mask(k))
      ) u_byte (
        .mclk_i    (mclk_i),
        .rst_n_i   (rst_n_i),
        .wr_en_i   (wr_fire && (req_slot == slot_type'(k))), // R10
        .wr_data_i (wb_dat_i[7:0]),
        .value_o   (slot_value[k])
      );
      assign table_flat[k*8 +: 8] = slot_value[k];

      if (slot_is_enable(k)) begin : g_en
        enable_reserved_a: assert property ( // R02
          @(posedge mclk_i) disable iff (!rst_n_i)
          slot_value[k][7] == 1'b0)
          else $error("enable byte bit 7 not zero");
      end else begin : g_gain
        gain_reserved_a: assert property ( // R01
          @(posedge mclk_i) disable iff (!rst_n_i)
          slot_value[k][7] == 1'b0 && slot_value[k][3] == 1'b0)
          else $error("gain byte reserved bit not zero");
      end
    end
  endgenerate

  rx_mode_select u_select (
    .mclk_i              (mclk_i),
    .rst_n_i             (rst_n_i),
    .mode_sel_i          (mode_sel_i),
    .table_i             (table_flat), // R11
    .main_splitter_o     (main_splitter_o),
    .pair_one_splitter_o (pair_one_splitter_o),
    .pair_two_splitter_o (pair_two_splitter_o),
    .channel_on_o        (channel_on_o),
    .gain_ch1_o          (gain_ch1_o),
    .gain_ch2_o          (gain_ch2_o),
    .gain_ch3_o          (gain_ch3_o),
    .gain_ch4_o          (gain_ch4_o),
    .mode_known_o        (mode_known_o)
  );

  // Helper state for checking write readback one cycle later.
  logic         chk_wr_fire;
  slot_type     chk_wr_slot;
  cfg_byte_type chk_wr_data;
  cfg_byte_type chk_rd_value;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      chk_wr_fire <= 1'b0;
      chk_wr_slot <= 4'h0;
      chk_wr_data <= 8'h00;
    end else begin
      chk_wr_fire <= wr_fire;
      chk_wr_slot <= req_slot;
      chk_wr_data <= wb_dat_i[7:0];
    end
  end

  // Snapshot of the addressed byte at the edge that takes a read; the answer must match it.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      chk_rd_value <= 8'h00;
    end else if (rd_fire && req_hit) begin
      chk_rd_value <= slot_value[req_slot];
    end
  end

  sequence read_request_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && req_hit;
  endsequence

  sequence ack_pulse_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  bus_answer_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> ack_pulse_s)
    else $error("bus request not answered in one cycle");

  // An answer with no request behind it would let a master finish a cycle it never started.
  ack_only_answer_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    wb_ack_o |-> $past(bus_req))
    else $error("ack without a request");

  dat_idle_zero_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside an ack");

  lane_off_write_a: assert property ( // R10
    @(posedge mclk_i) disable iff (!rst_n_i)
    (bus_req && wb_we_i && !wb_sel_i[0]) |=> $stable(table_flat))
    else $error("write without lane 0 changed the table");

  unmapped_write_a: assert property ( // R10
    @(posedge mclk_i) disable iff (!rst_n_i)
    (bus_req && wb_we_i && !req_hit) |=> $stable(table_flat))
    else $error("unmapped write changed the table");

  write_readback_a: assert property ( // R10
    @(posedge mclk_i) disable iff (!rst_n_i)
    chk_wr_fire |->
      slot_value[chk_wr_slot] == (chk_wr_data & slot_mask(int'(chk_wr_slot))))
    else $error("written value not held");

  read_data_a: assert property ( // R10
    @(posedge mclk_i) disable iff (!rst_n_i)
    read_request_s |=> wb_ack_o && wb_dat_o == {24'h00_0000, chk_rd_value})
    else $error("read data does not match register");

  mode10_gain_reset_a: assert property ( // R03
    @(posedge mclk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |->
      slot_value[1][6:4] == 3'h4 && slot_value[1][2:0] == 3'h4 &&
      slot_value[2][6:4] == 3'h4 && slot_value[2][2:0] == 3'h4)
    else $error("mode 10 gain reset wrong");

  mode10_chan_reset_a: assert property ( // R04
    @(posedge mclk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> slot_value[0][3:0] == 4'hF)
    else $error("mode 10 channel enables reset wrong");

  low_gain_reset_a: assert property ( // R05
    @(posedge mclk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |->
      slot_value[4] == 8'h00 && slot_value[5] == 8'h00 &&
      slot_value[7] == 8'h00 && slot_value[8] == 8'h00 &&
      slot_value[10] == 8'h00 && slot_value[11] == 8'h00)
    else $error("mode 11 to 13 gain reset wrong");

  mode11_en_reset_a: assert property ( // R06
    @(posedge mclk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |->
      slot_value[3][6] && slot_value[3][5] && !slot_value[3][4] &&
      slot_value[3][3:0] == 4'h8)
    else $error("mode 11 enable reset wrong");

  mode12_en_reset_a: assert property ( // R07
    @(posedge mclk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |->
      slot_value[6][6] && slot_value[6][5] && !slot_value[6][4] &&
      slot_value[6][3:0] == 4'h4)
    else $error("mode 12 enable reset wrong");

  mode13_en_reset_a: assert property ( // R08
    @(posedge mclk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |->
      slot_value[9][6] && !slot_value[9][5] && slot_value[9][4] &&
      slot_value[9][3:0] == 4'h2)
    else $error("mode 13 enable reset wrong");

  mode14_en_reset_a: assert property ( // R09
    @(posedge mclk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |->
      slot_value[12][6] && !slot_value[12][5] && slot_value[12][4] &&
      slot_value[12][3:0] == 4'h1)
    else $error("mode 14 enable reset wrong");

  mode11_apply_a: assert property ( // R11
    @(posedge mclk_i) disable iff (!rst_n_i)
    (mode_sel_i == `MODE_11) |=>
      mode_known_o &&
      main_splitter_o == $past(slot_value[3][6]) &&
      pair_two_splitter_o == $past(slot_value[3][4]) &&
      channel_on_o == $past(slot_value[3][3:0]) &&
      gain_ch1_o == $past(slot_value[4][6:4]) &&
      gain_ch4_o == $past(slot_value[5][2:0]))
    else $error("mode 11 settings not applied");

  mode10_apply_a: assert property ( // R11
    @(posedge mclk_i) disable iff (!rst_n_i)
    (mode_sel_i == `MODE_10) |=>
      pair_one_splitter_o == $past(slot_value[0][5]) &&
      gain_ch2_o == $past(slot_value[1][2:0]) &&
      gain_ch3_o == $past(slot_value[2][6:4]))
    else $error("mode 10 settings not applied");

  mode12_apply_a: assert property ( // R11
    @(posedge mclk_i) disable iff (!rst_n_i)
    (mode_sel_i == `MODE_12) |=>
      mode_known_o &&
      pair_one_splitter_o == $past(slot_value[6][5]) &&
      channel_on_o == $past(slot_value[6][3:0]) &&
      gain_ch2_o == $past(slot_value[7][2:0]) &&
      gain_ch3_o == $past(slot_value[8][6:4]))
    else $error("mode 12 settings not applied");

  mode13_apply_a: assert property ( // R11
    @(posedge mclk_i) disable iff (!rst_n_i)
    (mode_sel_i == `MODE_13) |=>
      mode_known_o &&
      main_splitter_o == $past(slot_value[9][6]) &&
      pair_two_splitter_o == $past(slot_value[9][4]) &&
      gain_ch1_o == $past(slot_value[10][6:4]) &&
      gain_ch4_o == $past(slot_value[11][2:0]))
    else $error("mode 13 settings not applied");

  // Mode 14 gains are not held in this table, so its gain outputs must stay at zero.
  mode14_apply_a: assert property ( // R11
    @(posedge mclk_i) disable iff (!rst_n_i)
    (mode_sel_i == `MODE_14) |=>
      mode_known_o &&
      main_splitter_o == $past(slot_value[12][6]) &&
      pair_two_splitter_o == $past(slot_value[12][4]) &&
      channel_on_o == $past(slot_value[12][3:0]) &&
      gain_ch1_o == 3'h0 && gain_ch4_o == 3'h0)
    else $error("mode 14 settings not applied");

  unknown_mode_a: assert property ( // R11
    @(posedge mclk_i) disable iff (!rst_n_i)
    (mode_sel_i < `MODE_10 || mode_sel_i > `MODE_14) |=>
      !mode_known_o && channel_on_o == 4'h0 && !main_splitter_o)
    else $error("unknown mode drives controls");

endmodule : rx_mode_config_bank

// ### rtl/rx_mode_defines.svh
// Offsets, field positions and reset values of the receiver mode table.
`ifndef RX_MODE_DEFINES_SVH
`define RX_MODE_DEFINES_SVH

`define SLOT_COUNT              13
`define SLOT_BITS               4
`define ADR_WIDTH               12
`define IDX_WIDTH               10

`define MODE10_ENABLES_IDX      10'h0F0
`define RX_MODE10_GAIN_CH12_IDX 10'h05F
`define RX_MODE10_GAIN_CH34_IDX 10'h060
`define RX_MODE11_ENABLES_IDX   10'h061
`define RX_MODE11_GAIN_CH12_IDX 10'h062
`define RX_MODE11_GAIN_CH34_IDX 10'h063
`define RX_MODE12_ENABLES_IDX   10'h064
`define RX_MODE12_GAIN_CH12_IDX 10'h065
`define RX_MODE12_GAIN_CH34_IDX 10'h066
`define RX_MODE13_ENABLES_IDX   10'h067
`define RX_MODE13_GAIN_CH12_IDX 10'h068
`define RX_MODE13_GAIN_CH34_IDX 10'h069
`define RX_MODE14_ENABLES_IDX   10'h06A

`define MAIN_SPLIT_BIT          6
`define PAIR_ONE_BIT            5
`define PAIR_TWO_BIT            4
`define GAIN_HI_LSB             4
`define GAIN_LO_LSB             0
`define ENABLE_MASK             8'h7F
`define GAIN_MASK               8'h77

`define RST_MODE10_ENABLES      8'h7F
`define RST_MODE10_GAIN         8'h44
`define RST_MODE11_ENABLES      8'h68
`define RST_MODE12_ENABLES      8'h64
`define RST_MODE13_ENABLES      8'h52
`define RST_MODE14_ENABLES      8'h51
`define RST_ZERO_GAIN           8'h00

`define MODE_10                 4'hA
`define MODE_11                 4'hB
`define MODE_12                 4'hC
`define MODE_13                 4'hD
`define MODE_14                 4'hE

`endif

// ### rtl/rx_mode_pkg.sv
// Types shared by the receiver mode table modules.
package rx_mode_pkg;

  typedef logic [7:0] cfg_byte_type;
  typedef logic [2:0] gain_code_type;
  typedef logic [3:0] mode_index_type;
  typedef logic [3:0] slot_type;

endpackage : rx_mode_pkg

// ### rtl/rx_cfg_byte.sv
// One configuration byte with a reset value and a mask of writable bits.
`timescale 1ns/1ps
module rx_cfg_byte
  import rx_mode_pkg::*;
#(
  parameter cfg_byte_type RESET_VALUE = 8'h00,
  parameter cfg_byte_type WRITE_MASK  = 8'hFF
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  input  wire logic         wr_en_i,
  input  wire cfg_byte_type wr_data_i,
  output cfg_byte_type      value_o
);

  // Masking on the way in keeps reserved bits at zero forever.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      value_o <= RESET_VALUE;
    end else if (wr_en_i) begin
      value_o <= wr_data_i & WRITE_MASK; // R10
    end
  end

endmodule : rx_cfg_byte

// ### rtl/rx_mode_select.sv
// Registered selection of one mode's settings for the receiver controls.
`timescale 1ns/1ps
`include "rx_mode_defines.svh"
module rx_mode_select
  import rx_mode_pkg::*;
(
  input  wire logic           mclk_i,
  input  wire logic           rst_n_i,
  input  wire mode_index_type mode_sel_i,
  input  wire logic [103:0]   table_i,
  output logic                main_splitter_o,
  output logic                pair_one_splitter_o,
  output logic                pair_two_splitter_o,
  output logic [3:0]          channel_on_o,
  output gain_code_type       gain_ch1_o,
  output gain_code_type       gain_ch2_o,
  output gain_code_type       gain_ch3_o,
  output gain_code_type       gain_ch4_o,
  output logic                mode_known_o
);

  cfg_byte_type en_pick;
  cfg_byte_type g12_pick;
  cfg_byte_type g34_pick;
  logic         known_pick;

  // Mode 14 gains live outside this table, so they are shown as zero here.
  always_comb begin
    en_pick    = 8'h00;
    g12_pick   = 8'h00;
    g34_pick   = 8'h00;
    known_pick = 1'b1;
    unique case (mode_sel_i)
      `MODE_10: begin
        en_pick  = table_i[0*8 +: 8];
        g12_pick = table_i[1*8 +: 8];
        g34_pick = table_i[2*8 +: 8];
      end
      `MODE_11: begin
        en_pick  = table_i[3*8 +: 8];
        g12_pick = table_i[4*8 +: 8];
        g34_pick = table_i[5*8 +: 8];
      end
      `MODE_12: begin
        en_pick  = table_i[6*8 +: 8];
        g12_pick = table_i[7*8 +: 8];
        g34_pick = table_i[8*8 +: 8];
      end
      `MODE_13: begin
        en_pick  = table_i[9*8 +: 8];
        g12_pick = table_i[10*8 +: 8];
        g34_pick = table_i[11*8 +: 8];
      end
      `MODE_14: begin
        en_pick = table_i[12*8 +: 8];
      end
      default: begin
        known_pick = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      main_splitter_o     <= 1'b0;
      pair_one_splitter_o <= 1'b0;
      pair_two_splitter_o <= 1'b0;
      channel_on_o        <= 4'h0;
      gain_ch1_o          <= 3'h0;
      gain_ch2_o          <= 3'h0;
      gain_ch3_o          <= 3'h0;
      gain_ch4_o          <= 3'h0;
      mode_known_o        <= 1'b0;
    end else begin
      main_splitter_o     <= en_pick[`MAIN_SPLIT_BIT]; // R02
      pair_one_splitter_o <= en_pick[`PAIR_ONE_BIT]; // R02
      pair_two_splitter_o <= en_pick[`PAIR_TWO_BIT]; // R02
      channel_on_o        <= en_pick[3:0]; // R02
      gain_ch1_o          <= g12_pick[`GAIN_HI_LSB +: 3]; // R01
      gain_ch2_o          <= g12_pick[`GAIN_LO_LSB +: 3]; // R01
      gain_ch3_o          <= g34_pick[`GAIN_HI_LSB +: 3]; // R01
      gain_ch4_o          <= g34_pick[`GAIN_LO_LSB +: 3]; // R01
      mode_known_o        <= known_pick; // R11
    end
  end

endmodule : rx_mode_select

// ### tb/rx_mode_config_bank_tb_top.sv
// Self-checking bench for the receiver mode table and its Wishbone slave.
`timescale 1ns/1ps
module rx_mode_config_bank_tb_top
  import rx_mode_pkg::*;
;
  logic           mclk_i;
  logic           rst_n_i;
  logic           wb_cyc_i;
  logic           wb_stb_i;
  logic           wb_we_i;
  logic [11:0]    wb_adr_i;
  logic [3:0]     wb_sel_i;
  logic [31:0]    wb_dat_i;
  logic           wb_ack_o;
  logic [31:0]    wb_dat_o;
  mode_index_type mode_sel_i;
  logic           main_splitter_o;
  logic           pair_one_splitter_o;
  logic           pair_two_splitter_o;
  logic [3:0]     channel_on_o;
  gain_code_type  gain_ch1_o;
  gain_code_type  gain_ch2_o;
  gain_code_type  gain_ch3_o;
  gain_code_type  gain_ch4_o;
  logic           mode_known_o;
  int             err_count;
  int             n_checks;
  cfg_byte_type   cur [13];

  // Slot order per mode is enables, gain pair one, gain pair two; mode 14 has enables only.
  logic [9:0]   idx_tab [13] = '{10'h0F0, 10'h05F, 10'h060, 10'h061, 10'h062, 10'h063,
                                 10'h064, 10'h065, 10'h066, 10'h067, 10'h068, 10'h069,
                                 10'h06A};
  cfg_byte_type rst_tab [13] = '{8'h7F, 8'h44, 8'h44, 8'h68, 8'h00, 8'h00, 8'h64, 8'h00,
                                 8'h00, 8'h52, 8'h00, 8'h00, 8'h51};
  cfg_byte_type mask_tab [13] = '{8'h7F, 8'h77, 8'h77, 8'h7F, 8'h77, 8'h77, 8'h7F, 8'h77,
                                  8'h77, 8'h7F, 8'h77, 8'h77, 8'h7F};

  rx_mode_config_bank u_dut (
    .mclk_i              (mclk_i),
    .rst_n_i             (rst_n_i),
    .wb_cyc_i            (wb_cyc_i),
    .wb_stb_i            (wb_stb_i),
    .wb_we_i             (wb_we_i),
    .wb_adr_i            (wb_adr_i),
    .wb_sel_i            (wb_sel_i),
    .wb_dat_i            (wb_dat_i),
    .wb_ack_o            (wb_ack_o),
    .wb_dat_o            (wb_dat_o),
    .mode_sel_i          (mode_sel_i),
    .main_splitter_o     (main_splitter_o),
    .pair_one_splitter_o (pair_one_splitter_o),
    .pair_two_splitter_o (pair_two_splitter_o),
    .channel_on_o        (channel_on_o),
    .gain_ch1_o          (gain_ch1_o),
    .gain_ch2_o          (gain_ch2_o),
    .gain_ch3_o          (gain_ch3_o),
    .gain_ch4_o          (gain_ch4_o),
    .mode_known_o        (mode_known_o)
  );

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  task automatic test_done;
    if (err_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // Values are taken before the edge's own updates land, so ack is seen as it was sampled.
  task automatic wb_cycle(input logic we, input logic [9:0] idx, input logic [3:0] sel,
                          input cfg_byte_type wdat, output logic [31:0] rdat);
    @(posedge mclk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= sel;
    wb_dat_i <= {24'h000000, wdat};
    // Only the watchdog ends a wait that never sees an answer.
    do begin
      @(posedge mclk_i);
    end while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb_cycle

  task automatic wb_write(input logic [9:0] idx, input cfg_byte_type d, input logic [3:0] sel);
    logic [31:0] dummy;
    wb_cycle(1'b1, idx, sel, d, dummy);
  endtask : wb_write

  task automatic wb_read(input logic [9:0] idx, output logic [31:0] d);
    wb_cycle(1'b0, idx, 4'hF, 8'h00, d);
  endtask : wb_read

  task automatic apply_reset;
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    repeat (5) @(posedge mclk_i);
    rst_n_i <= 1'b1;
  endtask : apply_reset

  task automatic check_reset_values;
    logic [31:0] d;
    for (int i = 0; i < 13; i++) begin
      wb_read(idx_tab[i], d);
      check(d, {24'h000000, rst_tab[i]}, "reset value");
      cur[i] = rst_tab[i];
    end
  endtask : check_reset_values

  task automatic check_modes;
    cfg_byte_type en;
    cfg_byte_type g12;
    cfg_byte_type g34;
    logic         known;
    for (int m = 9; m <= 15; m++) begin
      known = (m >= 10 && m <= 14);
      en  = known ? cur[3 * (m - 10)] : 8'h00;
      g12 = (known && m != 14) ? cur[3 * (m - 10) + 1] : 8'h00;
      g34 = (known && m != 14) ? cur[3 * (m - 10) + 2] : 8'h00;
      @(posedge mclk_i);
      mode_sel_i <= mode_index_type'(m);
      repeat (2) @(posedge mclk_i);
      check({25'h0, main_splitter_o, pair_one_splitter_o, pair_two_splitter_o, channel_on_o},
            {24'h0, 1'b0, en[6:0]}, "mode enables");
      check({20'h0, gain_ch1_o, gain_ch2_o, gain_ch3_o, gain_ch4_o},
            {20'h0, g12[6:4], g12[2:0], g34[6:4], g34[2:0]}, "mode gains");
      check({31'h0, mode_known_o}, {31'h0, known}, "mode known");
    end
  endtask : check_modes

  task automatic check_write_mask;
    logic [31:0]  d;
    cfg_byte_type pat;
    for (int i = 0; i < 13; i++) begin
      wb_write(idx_tab[i], 8'hFF, 4'h1);
      wb_read(idx_tab[i], d);
      check(d, {24'h000000, mask_tab[i]}, "reserved bits");
      pat = 8'h5A ^ cfg_byte_type'(i * 8'h13);
      cur[i] = pat & mask_tab[i];
      wb_write(idx_tab[i], pat, 4'h1);
      wb_read(idx_tab[i], d);
      check(d, {24'h000000, cur[i]}, "read back");
    end
  endtask : check_write_mask

  // Lane 0 off must leave the byte alone; the unmapped address after mode 14's enables must read zero.
  task automatic check_refused;
    logic [31:0] d;
    wb_write(idx_tab[3], 8'h00, 4'hE);
    wb_read(idx_tab[3], d);
    check(d, {24'h000000, cur[3]}, "lane 0 off write");
    wb_write(10'h06B, 8'hFF, 4'hF);
    wb_read(10'h06B, d);
    check(d, 32'h00000000, "unmapped read");
  endtask : check_refused

  initial begin
    err_count  = 0;
    n_checks   = 0;
    rst_n_i    = 1'b0;
    wb_cyc_i   = 1'b0;
    wb_stb_i   = 1'b0;
    wb_we_i    = 1'b0;
    wb_adr_i   = 12'h000;
    wb_sel_i   = 4'h0;
    wb_dat_i   = 32'h00000000;
    mode_sel_i = 4'h0;
    apply_reset();
    check_reset_values();
    check_modes();
    check_write_mask();
    check_modes();
    check_refused();
    apply_reset();
    check_reset_values();
    check_modes();
    test_done();
  end

  // The whole sequence needs well under 2000 cycles; this limit only catches a hang.
  initial begin
    repeat (20000) @(posedge mclk_i);
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done();
  end
endmodule : rx_mode_config_bank_tb_top
